/* core/dpm_pkg.sv */
package dpm_pkg;
   // pin slots of the dual-use pins
   localparam int unsigned NPIN = 9;
   localparam int unsigned IDX_DIAG_CLK = 0;
   localparam int unsigned IDX_SERIAL_IN = 1;
   localparam int unsigned IDX_PROBE_A = 2;
   localparam int unsigned IDX_PROBE_B = 3;
   localparam int unsigned IDX_PCL = 4;
   localparam int unsigned IDX_IO_CLK = 5;
   localparam int unsigned IDX_ARRAY_CLK = 6;
   localparam int unsigned IDX_GCLK_A = 7;
   localparam int unsigned IDX_GCLK_B = 8;
   localparam int unsigned NDIAG = 4;

   // internal node selection
   localparam int unsigned NODE_W = 16;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned SER_LEN = 8;
   localparam int unsigned CNT_W = 4;

   // apb register offsets
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFS_PIN_CFG = 12'h000;
   localparam logic [11:0] OFS_GLOBAL_USE = 12'h004;
   localparam logic [11:0] OFS_USER_OUT = 12'h008;
   localparam logic [11:0] OFS_USER_OE = 12'h00c;
   localparam logic [11:0] OFS_PROBE_SEL = 12'h010;
   localparam logic [11:0] OFS_PROBE_LOCK = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;
   localparam logic [11:0] OFS_IO_IN = 12'h01c;

   // field layouts
   localparam int unsigned CFG_W = 3;
   localparam int unsigned GU_W = 6;
   localparam int unsigned GU_IO_CLK = 0;
   localparam int unsigned GU_PCL = 1;
   localparam int unsigned GU_ARRAY_CLK = 2;
   localparam int unsigned GU_GCLK_A = 3;
   localparam int unsigned GU_GCLK_B = 4;
   localparam int unsigned GU_PCL_PRESET = 5;
   localparam int unsigned PSEL_A_LSB = 0;
   localparam int unsigned PSEL_B_LSB = 8;
   localparam int unsigned ST_MODE = 0;
   localparam int unsigned ST_LOCK = 1;
   localparam int unsigned ST_PCL = 2;
   localparam int unsigned ST_PIN_LSB = 8;

   // reset values
   localparam logic [26:0] RST_PIN_CFG = 27'h0000000;
   localparam logic [5:0] RST_GU = 6'h00;
   localparam logic [3:0] RST_SEL = 4'h0;
   localparam logic [8:0] RST_PINS = 9'h000;

   // user pin configuration codes
   typedef enum logic [2:0] {
      CFG_UNUSED = 3'h0,
      CFG_INPUT = 3'h1,
      CFG_OUTPUT = 3'h2,
      CFG_TRISTATE = 3'h3,
      CFG_BIDIR = 3'h4
   } dpm_cfg_t;
endpackage : dpm_pkg

/* core/dpm_pin_cell.sv */
`timescale 1ns/1ps
module dpm_pin_cell
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] cfg,
   input wire logic special,
   input wire logic spec_drive,
   input wire logic spec_val,
   input wire logic io_tick,
   input wire logic pcl_act,
   input wire logic pcl_preset,
   input wire logic user_dout,
   input wire logic user_den,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_n,
   output logic in_q
);
   logic out_q;
   logic drive_d;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_q <= 1'b0;
         in_q <= 1'b0;
      end
      else if (pcl_act)
      begin
         out_q <= pcl_preset;
         in_q <= pcl_preset;
      end
      else if (io_tick)
      begin
         out_q <= user_dout;
         in_q <= pin_i;
      end
   end

   always_comb
   begin
      drive_d = 1'b0;
      if (special)
         drive_d = spec_drive;
      else
         unique case (cfg)
            dpm_pkg::CFG_OUTPUT: drive_d = 1'b1;
            dpm_pkg::CFG_TRISTATE: drive_d = user_den;
            dpm_pkg::CFG_BIDIR: drive_d = user_den;
            default: drive_d = 1'b0;
         endcase
   end

   // registered pad drive, hi-z from reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_o <= 1'b0;
         pin_oe_n <= 1'b1;
      end
      else
      begin
         pin_o <= special ? spec_val : out_q;
         pin_oe_n <= !drive_d;
      end
   end

   unused_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
      !special && cfg == dpm_pkg::CFG_UNUSED |=> pin_oe_n)
      else $error("unused pin driven");
   out_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
      !special && (cfg == dpm_pkg::CFG_OUTPUT || cfg == dpm_pkg::CFG_INPUT)
      |=> pin_oe_n == ($past(cfg) == dpm_pkg::CFG_INPUT))
      else $error("pin buffer kind wrong");
   pcl_all_a: assert property (@(posedge pclk) disable iff (!presetn)
      pcl_act |=> out_q == $past(pcl_preset) && in_q == $past(pcl_preset))
      else $error("io register missed preset or clear");
   io_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
      io_tick && !pcl_act |=> out_q == $past(user_dout) ##1 pin_o == $past(out_q) || special)
      else $error("io register not clocked");
endmodule : dpm_pin_cell

/* core/dpm_top.sv */
`timescale 1ns/1ps
module dpm_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_sel,
   input wire logic [15:0] core_node,
   input wire logic diag_clock_pin_i,
   output logic diag_clock_pin_o,
   output logic diag_clock_pin_oe_n,
   input wire logic diag_serial_in_i,
   output logic diag_serial_in_o,
   output logic diag_serial_in_oe_n,
   input wire logic probe_out_a_i,
   output logic probe_out_a_o,
   output logic probe_out_a_oe_n,
   input wire logic probe_out_b_i,
   output logic probe_out_b_o,
   output logic probe_out_b_oe_n,
   input wire logic io_reg_preset_clear_pin_i,
   output logic io_reg_preset_clear_pin_o,
   output logic io_reg_preset_clear_pin_oe_n,
   input wire logic io_register_clock_pin_i,
   output logic io_register_clock_pin_o,
   output logic io_register_clock_pin_oe_n,
   input wire logic array_clock_pin_i,
   output logic array_clock_pin_o,
   output logic array_clock_pin_oe_n,
   input wire logic global_clock_a_pin_i,
   output logic global_clock_a_pin_o,
   output logic global_clock_a_pin_oe_n,
   input wire logic global_clock_b_pin_i,
   output logic global_clock_b_pin_o,
   output logic global_clock_b_pin_oe_n,
   output logic [8:0] user_in,
   output logic array_clk_tick,
   output logic clk_net_a_tick,
   output logic clk_net_b_tick
);
   localparam int unsigned NP = dpm_pkg::NPIN;

   logic [26:0] pin_cfg_q;
   logic [5:0] gu_q;
   logic [8:0] user_out_q;
   logic [8:0] user_oe_q;
   logic [3:0] sel_a_q;
   logic [3:0] sel_b_q;
   logic lock_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic [8:0] pin_prev_q;
   logic [31:0] prdata_q;
   logic [8:0] pin_i_w;
   logic [8:0] pin_o_w;
   logic [8:0] pin_oe_n_w;
   logic [8:0] special_w;
   logic [8:0] spec_drive_w;
   logic [8:0] spec_val_w;
   logic [8:0] rise_w;
   logic io_tick;
   logic pcl_act;
   logic probe_on;
   logic ser_tick;
   logic ser_load;
   logic wr_en;
   logic addr_ok;

   // gather pad inputs by slot
   assign pin_i_w = {global_clock_b_pin_i, global_clock_a_pin_i, array_clock_pin_i,
                     io_register_clock_pin_i, io_reg_preset_clear_pin_i, probe_out_b_i,
                     probe_out_a_i, diag_serial_in_i, diag_clock_pin_i};

   // previous pad levels for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_prev_q <= dpm_pkg::RST_PINS;
      else
         pin_prev_q <= pin_i_w;
   end

   assign rise_w = pin_i_w & ~pin_prev_q;

   assign special_w = {gu_q[dpm_pkg::GU_GCLK_B], gu_q[dpm_pkg::GU_GCLK_A],
                       gu_q[dpm_pkg::GU_ARRAY_CLK], gu_q[dpm_pkg::GU_IO_CLK],
                       gu_q[dpm_pkg::GU_PCL], {dpm_pkg::NDIAG{mode_sel}}};

   assign probe_on = mode_sel && !lock_q;

   // only probe pins drive in their special role
   always_comb
   begin
      spec_drive_w = '0;
      spec_val_w = '0;
      spec_drive_w[dpm_pkg::IDX_PROBE_A] = probe_on;
      spec_drive_w[dpm_pkg::IDX_PROBE_B] = probe_on;
      spec_val_w[dpm_pkg::IDX_PROBE_A] = probe_on && core_node[sel_a_q];
      spec_val_w[dpm_pkg::IDX_PROBE_B] = probe_on && core_node[sel_b_q];
   end

   assign io_tick = gu_q[dpm_pkg::GU_IO_CLK] && rise_w[dpm_pkg::IDX_IO_CLK];
   assign pcl_act = gu_q[dpm_pkg::GU_PCL] && pin_i_w[dpm_pkg::IDX_PCL];

   // one cell per dual-use pin
   for (genvar i = 0; i < NP; i++)
   begin : g_cell
      dpm_pin_cell u_cell
      (
         .pclk(pclk),
         .presetn(presetn),
         .cfg(pin_cfg_q[i*dpm_pkg::CFG_W +: dpm_pkg::CFG_W]),
         .special(special_w[i]),
         .spec_drive(spec_drive_w[i]),
         .spec_val(spec_val_w[i]),
         .io_tick(io_tick),
         .pcl_act(pcl_act),
         .pcl_preset(gu_q[dpm_pkg::GU_PCL_PRESET]),
         .user_dout(user_out_q[i]),
         .user_den(user_oe_q[i]),
         .pin_i(pin_i_w[i]),
         .pin_o(pin_o_w[i]),
         .pin_oe_n(pin_oe_n_w[i]),
         .in_q(user_in[i])
      );
   end

   // spread pad outputs back to named pins
   assign {global_clock_b_pin_o, global_clock_a_pin_o, array_clock_pin_o,
           io_register_clock_pin_o, io_reg_preset_clear_pin_o, probe_out_b_o,
           probe_out_a_o, diag_serial_in_o, diag_clock_pin_o} = pin_o_w;
   assign {global_clock_b_pin_oe_n, global_clock_a_pin_oe_n, array_clock_pin_oe_n,
           io_register_clock_pin_oe_n, io_reg_preset_clear_pin_oe_n, probe_out_b_oe_n,
           probe_out_a_oe_n, diag_serial_in_oe_n, diag_clock_pin_oe_n} = pin_oe_n_w;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         array_clk_tick <= 1'b0;
         clk_net_a_tick <= 1'b0;
         clk_net_b_tick <= 1'b0;
      end
      else
      begin
         array_clk_tick <= gu_q[dpm_pkg::GU_ARRAY_CLK] && rise_w[dpm_pkg::IDX_ARRAY_CLK];
         clk_net_a_tick <= gu_q[dpm_pkg::GU_GCLK_A] && rise_w[dpm_pkg::IDX_GCLK_A];
         clk_net_b_tick <= gu_q[dpm_pkg::GU_GCLK_B] && rise_w[dpm_pkg::IDX_GCLK_B];
      end
   end

   assign ser_tick = mode_sel && rise_w[dpm_pkg::IDX_DIAG_CLK];
   assign ser_load = ser_tick && cnt_q == 4'(dpm_pkg::SER_LEN - 1);

   // serial frame shifter, msb first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
      end
      else if (!mode_sel)
         cnt_q <= 4'h0;
      else if (ser_tick)
      begin
         shift_q <= {shift_q[6:0], pin_i_w[dpm_pkg::IDX_SERIAL_IN]};
         cnt_q <= ser_load ? 4'h0 : cnt_q + 4'h1;
      end
   end

   // apb decode
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   always_comb
   begin
      unique case (paddr)
         dpm_pkg::OFS_PIN_CFG, dpm_pkg::OFS_GLOBAL_USE, dpm_pkg::OFS_USER_OUT,
         dpm_pkg::OFS_USER_OE, dpm_pkg::OFS_PROBE_SEL, dpm_pkg::OFS_PROBE_LOCK,
         dpm_pkg::OFS_STATUS, dpm_pkg::OFS_IO_IN: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // software control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_cfg_q <= dpm_pkg::RST_PIN_CFG;
         gu_q <= dpm_pkg::RST_GU;
         user_out_q <= dpm_pkg::RST_PINS;
         user_oe_q <= dpm_pkg::RST_PINS;
      end
      else if (wr_en)
      begin
         if (paddr == dpm_pkg::OFS_PIN_CFG)
            pin_cfg_q <= pwdata[26:0];
         if (paddr == dpm_pkg::OFS_GLOBAL_USE)
            gu_q <= pwdata[5:0];
         if (paddr == dpm_pkg::OFS_USER_OUT)
            user_out_q <= pwdata[8:0];
         if (paddr == dpm_pkg::OFS_USER_OE)
            user_oe_q <= pwdata[8:0];
      end
   end

   // probe selects, serial frame wins over a same-cycle write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_a_q <= dpm_pkg::RST_SEL;
         sel_b_q <= dpm_pkg::RST_SEL;
      end
      else if (ser_load)
      begin
         sel_a_q <= {shift_q[2:0], pin_i_w[dpm_pkg::IDX_SERIAL_IN]};
         sel_b_q <= shift_q[6:3];
      end
      else if (wr_en && paddr == dpm_pkg::OFS_PROBE_SEL)
      begin
         sel_a_q <= pwdata[dpm_pkg::PSEL_A_LSB +: dpm_pkg::SEL_W];
         sel_b_q <= pwdata[dpm_pkg::PSEL_B_LSB +: dpm_pkg::SEL_W];
      end
   end

   // sticky lock, only reset clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_q <= 1'b0;
      else if (wr_en && paddr == dpm_pkg::OFS_PROBE_LOCK && pwdata[0])
         lock_q <= 1'b1;
   end

   // read data captured in setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         prdata_q <= 32'h0000_0000;
         unique case (paddr)
            dpm_pkg::OFS_PIN_CFG: prdata_q <= {5'h00, pin_cfg_q};
            dpm_pkg::OFS_GLOBAL_USE: prdata_q <= {26'h0000000, gu_q};
            dpm_pkg::OFS_USER_OUT: prdata_q <= {23'h000000, user_out_q};
            dpm_pkg::OFS_USER_OE: prdata_q <= {23'h000000, user_oe_q};
            dpm_pkg::OFS_PROBE_SEL: prdata_q <= {20'h00000, sel_b_q, 4'h0, sel_a_q};
            dpm_pkg::OFS_PROBE_LOCK: prdata_q <= {31'h00000000, lock_q};
            dpm_pkg::OFS_STATUS: prdata_q <= {15'h0000, pin_i_w, 5'h00, pcl_act,
                                              lock_q, mode_sel};
            dpm_pkg::OFS_IO_IN: prdata_q <= {23'h000000, user_in};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign prdata = prdata_q;

   diag_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_sel |=> diag_clock_pin_oe_n && diag_serial_in_oe_n)
      else $error("diagnostic input pin driven in mode high");
   user_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_sel && pin_cfg_q[2:0] == dpm_pkg::CFG_OUTPUT
      |=> !diag_clock_pin_oe_n && diag_clock_pin_o == $past(g_cell[0].u_cell.out_q))
      else $error("diagnostic pin not a user output in mode low");
   probe_a_a: assert property (@(posedge pclk) disable iff (!presetn)
      probe_on |=> !probe_out_a_oe_n && probe_out_a_o == $past(core_node[sel_a_q]))
      else $error("probe a not showing node");
   probe_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      probe_on |=> !probe_out_b_oe_n && probe_out_b_o == $past(core_node[sel_b_q]))
      else $error("probe b not showing node");
   probe_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      lock_q && mode_sel |=> lock_q && probe_out_a_oe_n && probe_out_b_oe_n
      && !probe_out_a_o && !probe_out_b_o)
      else $error("probe active after lock");
   pcl_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gu_q[dpm_pkg::GU_PCL] && pin_cfg_q[dpm_pkg::IDX_PCL*dpm_pkg::CFG_W +: dpm_pkg::CFG_W]
      == dpm_pkg::CFG_OUTPUT |=> !io_reg_preset_clear_pin_oe_n
      && io_reg_preset_clear_pin_o == $past(g_cell[4].u_cell.out_q))
      else $error("preset/clear pin not a user pin while unused");
   array_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      array_clk_tick == ($past(gu_q[dpm_pkg::GU_ARRAY_CLK] && array_clock_pin_i)
      && !$past(array_clock_pin_i, 2)))
      else $error("array clock tick wrong");
   clk_net_a: assert property (@(posedge pclk) disable iff (!presetn)
      gu_q[dpm_pkg::GU_GCLK_A] && gu_q[dpm_pkg::GU_GCLK_B]
      |=> global_clock_a_pin_oe_n && global_clock_b_pin_oe_n)
      else $error("clock network pin driven");
   serial_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_sel |=> cnt_q == 4'h0 && $stable(shift_q))
      else $error("serial data taken in mode low");

   probe_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      probe_on ##1 !probe_out_a_oe_n);
   ser_load_c: cover property (@(posedge pclk) disable iff (!presetn) ser_load);
   lock_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(lock_q) && mode_sel);
   pcl_c: cover property (@(posedge pclk) disable iff (!presetn) pcl_act ##1 io_tick);
endmodule : dpm_top

/* tb/dpm_probe_equip.sv */
`timescale 1ns/1ps
module dpm_probe_equip
(
   input wire logic pclk,
   output logic mode_sel,
   output logic diag_clock_pin,
   output logic diag_serial_in
);
   logic busy;
   // idle: clock still, data line toggles so no stale bit looks valid
   initial
   begin
      mode_sel = 1'b0;
      diag_clock_pin = 1'b0;
      diag_serial_in = 1'b0;
      busy = 1'b0;
   end
   always @(posedge pclk)
      if (!busy) diag_serial_in <= ~diag_serial_in;
   // drive the mode pin level
   task set_mode(input logic m);
      @(posedge pclk);
      mode_sel <= m;
      repeat (3) @(posedge pclk);
   endtask : set_mode
   task send_frame(input logic [7:0] f);
      integer i;
      busy = 1'b1;
      for (i = 7; i >= 0; i--)
      begin
         @(posedge pclk);
         diag_serial_in <= f[i];
         repeat (2) @(posedge pclk);
         diag_clock_pin <= 1'b1;
         repeat (2) @(posedge pclk);
         diag_clock_pin <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      busy = 1'b0;
   endtask : send_frame
endmodule : dpm_probe_equip

/* tb/dpm_tb_top.sv */
`timescale 1ns/1ps
module dpm_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] core_node, node_prev;
   logic [8:0] pin_o, oe_n, ext, pin_i, user_in;
   logic t_arr, t_a, t_b, exp_lock, watch, err;
   logic [1:0] pr_ext = 2'b00;
   wire mode_sel, diag_clock_pin, diag_serial_in;
   integer bad_count, samples_checked, seed, rnd, exp_a, exp_b, n_arr, n_a, n_b, k;
   integer e_arr, e_a, e_b;
   // pad level: design drives when enabled, else far side
   assign pin_i = (oe_n & {ext[8:4], pr_ext, diag_serial_in, diag_clock_pin}) | (~oe_n & pin_o);
   dpm_probe_equip i_dpm_probe_equip (.pclk(pclk), .mode_sel(mode_sel), .diag_clock_pin(diag_clock_pin), .diag_serial_in(diag_serial_in));
   dpm_top i_dpm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_sel(mode_sel), .core_node(core_node),
      .diag_clock_pin_i(pin_i[0]), .diag_clock_pin_o(pin_o[0]), .diag_clock_pin_oe_n(oe_n[0]),
      .diag_serial_in_i(pin_i[1]), .diag_serial_in_o(pin_o[1]),
      .diag_serial_in_oe_n(oe_n[1]), .probe_out_a_i(pin_i[2]), .probe_out_a_o(pin_o[2]),
      .probe_out_a_oe_n(oe_n[2]), .probe_out_b_i(pin_i[3]), .probe_out_b_o(pin_o[3]),
      .probe_out_b_oe_n(oe_n[3]), .io_reg_preset_clear_pin_i(pin_i[4]),
      .io_reg_preset_clear_pin_o(pin_o[4]), .io_reg_preset_clear_pin_oe_n(oe_n[4]),
      .io_register_clock_pin_i(pin_i[5]), .io_register_clock_pin_o(pin_o[5]),
      .io_register_clock_pin_oe_n(oe_n[5]), .array_clock_pin_i(pin_i[6]),
      .array_clock_pin_o(pin_o[6]), .array_clock_pin_oe_n(oe_n[6]),
      .global_clock_a_pin_i(pin_i[7]), .global_clock_a_pin_o(pin_o[7]),
      .global_clock_a_pin_oe_n(oe_n[7]), .global_clock_b_pin_i(pin_i[8]),
      .global_clock_b_pin_o(pin_o[8]), .global_clock_b_pin_oe_n(oe_n[8]), .user_in(user_in),
      .array_clk_tick(t_arr), .clk_net_a_tick(t_a), .clk_net_b_tick(t_b));
   // 200 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   // one apb transfer, held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50)
      begin
         bad_count++;
         stop_test();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : apb
   task io_pulse;
      ext[5] <= 1'b1;
      repeat (2) @(posedge pclk);
      ext[5] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : io_pulse
   // live probe model against pins, node seen one edge earlier
   always @(posedge pclk)
   begin
      if (watch)
      begin
         chk(pin_o[2], exp_lock ? 1'b0 : node_prev[exp_a]);
         chk(pin_o[3], exp_lock ? 1'b0 : node_prev[exp_b]);
         chk(oe_n[3:2], {2{exp_lock}});
      end
      node_prev = core_node;
      rnd = $random(seed);
      core_node <= rnd[15:0];
      pr_ext <= rnd[17:16];
   end
   // clock-network tick counters
   always @(posedge pclk)
   begin
      n_arr += (t_arr === 1'b1);
      n_a += (t_a === 1'b1);
      n_b += (t_b === 1'b1);
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, ext, watch, exp_lock} = '0;
      {bad_count, samples_checked, n_arr, n_a, n_b} = '0;
      seed = 32'hb4b38693;
      core_node = 16'h0000;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(oe_n, 9'h1ff);
      apb(1'b0, dpm_pkg::OFS_PIN_CFG, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(r, 32'h0);
      chk(err, 1'b1);
      // each pin code on a user pin
      apb(1'b1, dpm_pkg::OFS_USER_OE, 32'h1ff);
      for (k = 0; k < 5; k++)
      begin
         apb(1'b1, dpm_pkg::OFS_PIN_CFG, k << 24);
         chk(oe_n[8], k < 2);
      end
      apb(1'b1, dpm_pkg::OFS_USER_OE, 32'h0);
      chk(oe_n[8], 1'b1);
      apb(1'b1, dpm_pkg::OFS_PIN_CFG, 32'h0);
      chk(oe_n[2], 1'b1);
      apb(1'b1, dpm_pkg::OFS_PROBE_SEL, 32'h0903);
      exp_a = 3;
      exp_b = 9;
      i_dpm_probe_equip.set_mode(1'b1);
      chk(oe_n[2], 1'b0);
      watch = 1'b1;
      repeat (30) @(posedge pclk);
      watch = 1'b0;
      i_dpm_probe_equip.send_frame(8'h5a);
      exp_a = 10;
      exp_b = 5;
      watch = 1'b1;
      repeat (30) @(posedge pclk);
      watch = 1'b0;
      i_dpm_probe_equip.set_mode(1'b0);
      i_dpm_probe_equip.send_frame(8'h21);
      chk(oe_n[3:2], 2'b11);
      i_dpm_probe_equip.set_mode(1'b1);
      apb(1'b0, dpm_pkg::OFS_PROBE_SEL, 32'h0);
      chk(r, 32'h050a);
      apb(1'b1, dpm_pkg::OFS_PROBE_LOCK, 32'h1);
      exp_lock = 1'b1;
      i_dpm_probe_equip.set_mode(1'b0);
      i_dpm_probe_equip.set_mode(1'b1);
      apb(1'b1, dpm_pkg::OFS_PROBE_LOCK, 32'h0);
      watch = 1'b1;
      repeat (30) @(posedge pclk);
      watch = 1'b0;
      i_dpm_probe_equip.set_mode(1'b0);
      apb(1'b1, dpm_pkg::OFS_GLOBAL_USE, 32'h1c);
      {n_arr, n_a, n_b} = '0;
      {e_arr, e_a, e_b} = '0;
      // random pin levels, expected ticks counted from rising levels
      repeat (12)
      begin
         r = $random(seed);
         e_arr += r[0] & ~ext[6];
         e_a += r[1] & ~ext[7];
         e_b += r[2] & ~ext[8];
         ext[8:6] <= r[2:0];
         repeat (2) @(posedge pclk);
      end
      ext[8:6] <= 3'h0;
      repeat (4) @(posedge pclk);
      chk(n_arr, e_arr);
      chk(n_a, e_a);
      chk(n_b, e_b);
      apb(1'b1, dpm_pkg::OFS_PIN_CFG, 32'h2002);
      apb(1'b1, dpm_pkg::OFS_USER_OUT, 32'h011);
      apb(1'b1, dpm_pkg::OFS_GLOBAL_USE, 32'h1);
      chk({oe_n[4], pin_o[4]}, 2'b00);
      io_pulse();
      chk({pin_o[4], pin_o[0]}, 2'b11);
      chk(user_in[8:4], 5'h02);
      // clear then preset over the io clock
      apb(1'b1, dpm_pkg::OFS_GLOBAL_USE, 32'h3);
      ext[4] <= 1'b1;
      apb(1'b0, dpm_pkg::OFS_STATUS, 32'h0);
      chk(r[2], 1'b1);
      io_pulse();
      chk(pin_o[0], 1'b0);
      apb(1'b1, dpm_pkg::OFS_GLOBAL_USE, 32'h23);
      apb(1'b1, dpm_pkg::OFS_USER_OUT, 32'h0);
      io_pulse();
      chk(pin_o[0], 1'b1);
      ext[4] <= 1'b0;
      io_pulse();
      chk(pin_o[0], 1'b0);
      stop_test();
   end
endmodule : dpm_tb_top
